// ===== inc/bcdu_regs.vh
`ifndef BCDU_REGS_VH
`define BCDU_REGS_VH

// Register byte offsets on the Avalon-MM slave
`define BCDU_OFS_ACC 6'h00
`define BCDU_OFS_AUX 6'h04
`define BCDU_OFS_STATUS_WORD_LOW_HALF 6'h08
`define BCDU_OFS_STATUS_WORD_HIGH_HALF 6'h0C
`define BCDU_OFS_SADDR 6'h10
`define BCDU_OFS_SFR 6'h14
`define BCDU_OFS_CMD 6'h18
`define BCDU_OFS_STAT 6'h1C

// Reset values
`define BCDU_RST_BYTE 8'h00
`define BCDU_RST_CMD 12'h000

// Low status-word half bit positions
`define BCDU_PSW_S 7
`define BCDU_PSW_Z 6
`define BCDU_PSW_AC 4
`define BCDU_PSW_PV 2
`define BCDU_PSW_CY 0
`define BCDU_PSW_CY_POS 3'h0

// Command word field layout
`define BCDU_CMD_OP_HI 3
`define BCDU_CMD_OP_LO 0
`define BCDU_CMD_BIT_HI 6
`define BCDU_CMD_BIT_LO 4
`define BCDU_CMD_SP_HI 9
`define BCDU_CMD_SP_LO 7
`define BCDU_CMD_INV 10
`define BCDU_CMD_DIR 11
`define BCDU_CMD_W 12

// Operation codes
`define BCDU_OP_NOP 4'h0
`define BCDU_OP_ADJ_ADD 4'h1
`define BCDU_OP_ADJ_SUB 4'h2
`define BCDU_OP_SIGN_EXT 4'h3
`define BCDU_OP_MOVE 4'h4
`define BCDU_OP_AND 4'h5
`define BCDU_OP_OR 4'h6
`define BCDU_OP_XOR 4'h7
`define BCDU_OP_SET 4'h8
`define BCDU_OP_CLR 4'h9
`define BCDU_OP_INV 4'hA

// Bit operand spaces
`define BCDU_SP_SADDR 3'h0
`define BCDU_SP_SFR 3'h1
`define BCDU_SP_ACC 3'h2
`define BCDU_SP_AUX 3'h3
`define BCDU_SP_STATUS_WORD_HIGH_HALF 3'h4
`define BCDU_SP_STATUS_WORD_LOW_HALF 3'h5
`define BCDU_SP_CY 3'h6

// Decimal adjustment and sign-extension constants
`define BCDU_FIX_LO 8'h06
`define BCDU_FIX_HI 8'h60
`define BCDU_FIX_BOTH 8'h66
`define BCDU_NIB_LIMIT 4'h9
`define BCDU_NIB_TEN 4'hA
`define BCDU_EXT_NEG 8'hFF
`define BCDU_EXT_POS 8'h00

`endif

// ===== rtl/bcdu_core.v
`timescale 1ns/1ps
`include "bcdu_regs.vh"

module bcdu_core #(
  parameter ADDR_W = 6
) (
  input wire mclk,
  input wire nrst,
  input wire [ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg intAckBlock
);

  reg [7:0] acc_q;
  reg [7:0] aux_q;
  reg [7:0] status_word_low_half_q;
  reg [7:0] status_word_high_half_q;
  reg [7:0] saddr_q;
  reg [7:0] sfr_q;
  reg [`BCDU_CMD_W-1:0] cmd_q;

  reg [7:0] acc_d;
  reg [7:0] aux_d;
  reg [7:0] status_word_low_half_d;
  reg [7:0] status_word_high_half_d;
  reg [7:0] saddr_d;
  reg [7:0] sfr_d;
  reg intAckBlock_d;

  // Bus handshake: one wait cycle, then the access completes on the edge
  // where waitrequest is seen low.
  wire busReq = avs_read | avs_write;
  wire accessDone = busReq & ~avs_waitrequest;
  wire wrDone = avs_write & accessDone;
  wire cmdExec = wrDone & (avs_address == `BCDU_OFS_CMD);

  wire [`BCDU_CMD_W-1:0] cmdWord = avs_writedata[`BCDU_CMD_W-1:0];
  wire [3:0] opCode = cmdWord[`BCDU_CMD_OP_HI:`BCDU_CMD_OP_LO];
  wire [2:0] bitSel = cmdWord[`BCDU_CMD_BIT_HI:`BCDU_CMD_BIT_LO];
  wire [2:0] space = cmdWord[`BCDU_CMD_SP_HI:`BCDU_CMD_SP_LO];
  wire invSrc = cmdWord[`BCDU_CMD_INV];
  wire toCarry = ~cmdWord[`BCDU_CMD_DIR];

  wire carryIn = status_word_low_half_q[`BCDU_PSW_CY];
  wire auxCarryIn = status_word_low_half_q[`BCDU_PSW_AC];

  // Decimal adjust after addition
  wire [3:0] loNib = acc_q[3:0];
  wire [3:0] hiNib = acc_q[7:4];
  wire loFixAdd = (loNib >= `BCDU_NIB_TEN) | auxCarryIn;
  wire hiFixAdd = carryIn | (hiNib >= `BCDU_NIB_TEN) |
    ((loNib >= `BCDU_NIB_TEN) & (hiNib >= `BCDU_NIB_LIMIT));
  reg [7:0] addFix;
  always @* begin
    case ({hiFixAdd, loFixAdd})
      2'b01: addFix = `BCDU_FIX_LO;
      2'b10: addFix = `BCDU_FIX_HI;
      2'b11: addFix = `BCDU_FIX_BOTH;
      default: addFix = `BCDU_RST_BYTE;
    endcase
  end
  wire [7:0] adjAddRes = acc_q + addFix;

  // Decimal adjust after subtraction; flags only choose the correction
  reg [7:0] subFix;
  always @* begin
    case ({carryIn, auxCarryIn})
      2'b01: subFix = `BCDU_FIX_LO;
      2'b10: subFix = `BCDU_FIX_HI;
      2'b11: subFix = `BCDU_FIX_BOTH;
      default: subFix = `BCDU_RST_BYTE;
    endcase
  end
  wire [7:0] adjSubRes = acc_q - subFix;

  // Byte operand chosen by the command's space field
  reg [7:0] opByte;
  always @* begin
    case (space)
      `BCDU_SP_SADDR: opByte = saddr_q;
      `BCDU_SP_SFR: opByte = sfr_q;
      `BCDU_SP_ACC: opByte = acc_q;
      `BCDU_SP_AUX: opByte = aux_q;
      `BCDU_SP_STATUS_WORD_HIGH_HALF: opByte = status_word_high_half_q;
      `BCDU_SP_STATUS_WORD_LOW_HALF: opByte = status_word_low_half_q;
      default: opByte = {7'h00, carryIn};
    endcase
  end
  wire isCySpace = (space == `BCDU_SP_CY);
  wire rawBit = isCySpace ? carryIn : opByte[bitSel];
  // Inversion only feeds AND and OR; the stored operand is never rewritten
  wire logicSrc = rawBit ^ invSrc;

  // New value of the addressed bit for the write-back forms
  reg wrBit;
  reg wrEn;
  always @* begin
    wrBit = rawBit;
    wrEn = 1'b0;
    case (opCode)
      `BCDU_OP_MOVE: begin
        wrBit = carryIn;
        wrEn = ~toCarry;
      end
      `BCDU_OP_SET: begin
        wrBit = 1'b1;
        wrEn = 1'b1;
      end
      `BCDU_OP_CLR: begin
        wrBit = 1'b0;
        wrEn = 1'b1;
      end
      `BCDU_OP_INV: begin
        wrBit = ~rawBit;
        wrEn = 1'b1;
      end
      default: begin
        wrBit = rawBit;
        wrEn = 1'b0;
      end
    endcase
  end

  // Carry result for the carry-destination forms
  reg cyNew;
  reg cyEn;
  always @* begin
    cyNew = carryIn;
    cyEn = 1'b0;
    case (opCode)
      `BCDU_OP_MOVE: begin
        cyNew = rawBit;
        cyEn = toCarry;
      end
      `BCDU_OP_AND: begin
        cyNew = carryIn & logicSrc;
        cyEn = 1'b1;
      end
      `BCDU_OP_OR: begin
        cyNew = carryIn | logicSrc;
        cyEn = 1'b1;
      end
      `BCDU_OP_XOR: begin
        cyNew = carryIn ^ rawBit;
        cyEn = 1'b1;
      end
      default: begin
        cyNew = carryIn;
        cyEn = 1'b0;
      end
    endcase
  end

  // Targeting the carry space writes bit zero of the low status half
  wire [2:0] wrPos = isCySpace ? `BCDU_PSW_CY_POS : bitSel;
  wire [2:0] wrSpace = isCySpace ? `BCDU_SP_STATUS_WORD_LOW_HALF : space;
  wire writesPsw = wrEn & ((wrSpace == `BCDU_SP_STATUS_WORD_LOW_HALF) | (wrSpace == `BCDU_SP_STATUS_WORD_HIGH_HALF));
  wire writesCtl = wrEn & (wrSpace == `BCDU_SP_SFR);

  function [7:0] setBit;
    input [7:0] val;
    input [2:0] pos;
    input b;
    begin
      setBit = val;
      setBit[pos] = b;
    end
  endfunction

  function [7:0] adjFlags;
    input [7:0] program_status_word;
    input [7:0] res;
    input cy;
    input ac;
    begin
      adjFlags = program_status_word;
      adjFlags[`BCDU_PSW_S] = res[7];
      adjFlags[`BCDU_PSW_Z] = (res == `BCDU_RST_BYTE);
      adjFlags[`BCDU_PSW_PV] = ~^res;
      adjFlags[`BCDU_PSW_AC] = ac;
      adjFlags[`BCDU_PSW_CY] = cy;
    end
  endfunction

  // Next-state of the datapath registers
  always @* begin
    acc_d = acc_q;
    aux_d = aux_q;
    status_word_low_half_d = status_word_low_half_q;
    status_word_high_half_d = status_word_high_half_q;
    saddr_d = saddr_q;
    sfr_d = sfr_q;
    if (wrDone) begin
      case (avs_address)
        `BCDU_OFS_ACC: acc_d = avs_writedata[7:0];
        `BCDU_OFS_AUX: aux_d = avs_writedata[7:0];
        `BCDU_OFS_STATUS_WORD_LOW_HALF: status_word_low_half_d = avs_writedata[7:0];
        `BCDU_OFS_STATUS_WORD_HIGH_HALF: status_word_high_half_d = avs_writedata[7:0];
        `BCDU_OFS_SADDR: saddr_d = avs_writedata[7:0];
        `BCDU_OFS_SFR: sfr_d = avs_writedata[7:0];
        default: acc_d = acc_q;
      endcase
    end
    if (cmdExec) begin
      case (opCode)
        `BCDU_OP_ADJ_ADD: begin
          acc_d = adjAddRes;
          status_word_low_half_d = adjFlags(status_word_low_half_q, adjAddRes, hiFixAdd, loFixAdd);
        end
        `BCDU_OP_ADJ_SUB: begin
          acc_d = adjSubRes;
          status_word_low_half_d = adjFlags(status_word_low_half_q, adjSubRes, carryIn, auxCarryIn);
        end
        `BCDU_OP_SIGN_EXT: begin
          // Flags are not touched here
          aux_d = acc_q;
          acc_d = acc_q[7] ? `BCDU_EXT_NEG : `BCDU_EXT_POS;
        end
        default: begin
          if (cyEn) begin
            status_word_low_half_d = setBit(status_word_low_half_q, `BCDU_PSW_CY_POS, cyNew);
          end
          if (wrEn) begin
            case (wrSpace)
              `BCDU_SP_SADDR: saddr_d = setBit(saddr_q, wrPos, wrBit);
              `BCDU_SP_SFR: sfr_d = setBit(sfr_q, wrPos, wrBit);
              `BCDU_SP_ACC: acc_d = setBit(acc_q, wrPos, wrBit);
              `BCDU_SP_AUX: aux_d = setBit(aux_q, wrPos, wrBit);
              `BCDU_SP_STATUS_WORD_HIGH_HALF: status_word_high_half_d = setBit(status_word_high_half_q, wrPos, wrBit);
              default: status_word_low_half_d = setBit(status_word_low_half_q, wrPos, wrBit);
            endcase
          end
        end
      endcase
    end
  end

  // Interrupt acknowledge block: raised by a status word or control register
  // bus write, dropped once the next instruction has executed. A command whose bit
  // write-back lands in them keeps the block raised, so the set wins.
  wire pswBusWrite = wrDone &
    ((avs_address == `BCDU_OFS_STATUS_WORD_LOW_HALF) | (avs_address == `BCDU_OFS_STATUS_WORD_HIGH_HALF) |
    (avs_address == `BCDU_OFS_SFR));
  wire pswCmdWrite = cmdExec & (writesPsw | writesCtl);
  always @* begin
    intAckBlock_d = intAckBlock;
    if (cmdExec) begin
      intAckBlock_d = 1'b0;
    end
    if (pswBusWrite | pswCmdWrite) begin
      intAckBlock_d = 1'b1;
    end
  end

  // Read mux; unmapped offsets read zero
  reg [31:0] rdMux;
  always @* begin
    case (avs_address)
      `BCDU_OFS_ACC: rdMux = {24'h000000, acc_q};
      `BCDU_OFS_AUX: rdMux = {24'h000000, aux_q};
      `BCDU_OFS_STATUS_WORD_LOW_HALF: rdMux = {24'h000000, status_word_low_half_q};
      `BCDU_OFS_STATUS_WORD_HIGH_HALF: rdMux = {24'h000000, status_word_high_half_q};
      `BCDU_OFS_SADDR: rdMux = {24'h000000, saddr_q};
      `BCDU_OFS_SFR: rdMux = {24'h000000, sfr_q};
      `BCDU_OFS_CMD: rdMux = {20'h00000, cmd_q};
      `BCDU_OFS_STAT: rdMux = {31'h00000000, intAckBlock};
      default: rdMux = 32'h00000000;
    endcase
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      acc_q <= `BCDU_RST_BYTE;
      aux_q <= `BCDU_RST_BYTE;
      status_word_low_half_q <= `BCDU_RST_BYTE;
      status_word_high_half_q <= `BCDU_RST_BYTE;
      saddr_q <= `BCDU_RST_BYTE;
      sfr_q <= `BCDU_RST_BYTE;
      cmd_q <= `BCDU_RST_CMD;
      intAckBlock <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      acc_q <= acc_d;
      aux_q <= aux_d;
      status_word_low_half_q <= status_word_low_half_d;
      status_word_high_half_q <= status_word_high_half_d;
      saddr_q <= saddr_d;
      sfr_q <= sfr_d;
      intAckBlock <= intAckBlock_d;
      if (cmdExec) begin
        cmd_q <= cmdWord;
      end
      // Waitrequest drops for exactly one cycle per request; read data is
      // captured then so it stands at the completing edge.
      if (busReq & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        if (avs_read) begin
          avs_readdata <= rdMux;
        end
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

endmodule // bcdu_core

// ===== verif/bcdu_checker.sv
`timescale 1ns/1ps
`include "bcdu_regs.vh"

module bcdu_checker #(
  parameter ADDR_W = 6
) (
  input wire mclk,
  input wire nrst,
  input wire [ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire intAckBlock
);
  wire wrDone = avs_write && !avs_waitrequest;
  wire rdDone = avs_read && !avs_waitrequest;
  wire cmdDone = wrDone && avs_address == `BCDU_OFS_CMD;
  wire statWr = wrDone && (avs_address == `BCDU_OFS_STATUS_WORD_LOW_HALF || avs_address == `BCDU_OFS_STATUS_WORD_HIGH_HALF ||
                avs_address == `BCDU_OFS_SFR);

  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence oneWait;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_wait_once: assert property (taken |=> oneWait)
    else $error("waitrequest not low for exactly one cycle");
  a_wait_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped without a request");
  a_block_set: assert property (statWr |=> intAckBlock)
    else $error("status write did not hold off interrupts");
  a_block_rise: assert property ($rose(intAckBlock) |-> $past(wrDone))
    else $error("interrupt hold-off rose without a write");
  a_block_fall: assert property ($fell(intAckBlock) |-> $past(cmdDone))
    else $error("interrupt hold-off fell without a command");
  a_block_hold: assert property (intAckBlock && !cmdDone |=> intAckBlock)
    else $error("interrupt hold-off released early");
  a_stat_mirror: assert property (rdDone && avs_address == `BCDU_OFS_STAT |->
    avs_readdata == {31'h0, intAckBlock})
    else $error("status readback differs from hold-off output");
  a_unmapped_zero: assert property (rdDone && avs_address >= 6'h20 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_byte_width: assert property (rdDone && avs_address < `BCDU_OFS_CMD |->
    avs_readdata[31:8] == 24'h0)
    else $error("byte register upper bits not zero");
endmodule // bcdu_checker

// ===== verif/testbench.sv
`timescale 1ns/1ps
`include "bcdu_regs.vh"

module testbench;
  reg mclk, nrst, avsRead, avsWrite;
  reg [5:0] avsAddress;
  reg [31:0] avsWritedata, v;
  wire [31:0] avsReaddata;
  wire avsWaitrequest, intAckBlock;
  reg [15:0] e;
  reg [43:0] t;
  integer fails, compares, i;
  // Adjust vectors {A, status low half} as a BCD add (even) or subtract (odd) leaves them
  localparam [255:0] VEC = {128'h9800_2021_F501_B010_FF11_2130_0000_1211,
    128'hF911_3B00_4B3A_A500_F001_9900_4500_9A00};

  bcdu_core bcdu_core_inst (.mclk(mclk), .nrst(nrst), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .intAckBlock(intAckBlock));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task report_and_stop;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask

  task wr(input [5:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      avsAddress <= a;
      avsWritedata <= d;
      avsWrite <= 1'b1;
      @(posedge mclk);
      while (avsWaitrequest !== 1'b0) @(posedge mclk);
      avsWrite <= 1'b0;
    end
  endtask

  // Read and compare in one; data is taken at the edge that ends the wait
  task rc(input [5:0] a, input [31:0] x);
    begin
      @(posedge mclk);
      avsAddress <= a;
      avsRead <= 1'b1;
      @(posedge mclk);
      while (avsWaitrequest !== 1'b0) @(posedge mclk);
      v = avsReaddata;
      avsRead <= 1'b0;
      compares = compares + 1;
      if (v !== x) begin
        fails = fails + 1;
        $display("MISMATCH reg %h exp %h got %h", a, x, v);
      end
    end
  endtask

  // Pin level is read mid-cycle, well clear of the edge that launches it
  task cp(input x);
    begin
      @(negedge mclk);
      compares = compares + 1;
      if (intAckBlock !== x) begin
        fails = fails + 1;
        $display("MISMATCH intAckBlock exp %b got %b", x, intAckBlock);
      end
    end
  endtask

  task op(input [11:0] c, input [7:0] a, input [7:0] p);
    begin
      wr(`BCDU_OFS_ACC, {24'h0, a});
      wr(`BCDU_OFS_STATUS_WORD_LOW_HALF, {24'h0, p});
      wr(`BCDU_OFS_CMD, {20'h0, c});
    end
  endtask

  function [15:0] adj(input sub, input [7:0] a, input [7:0] p);
    reg lo, hi;
    reg [7:0] f, r;
    begin
      lo = sub ? p[4] : (a[3:0] >= 4'hA || p[4]);
      hi = sub ? p[0] : (a[7:4] >= 4'hA || p[0] || (a[3:0] >= 4'hA && a[7:4] >= 4'h9));
      f = {1'b0, hi, hi, 2'b00, lo, lo, 1'b0};
      r = sub ? a - f : a + f;
      adj = {r, r[7], r == 8'h00, p[5], lo, p[3], ~^r, p[1], hi};
    end
  endfunction

  // Bit cases {cmd, status in, status out, offset, value}; later ones reuse earlier state
  function [43:0] bt(input integer k);
    case (k)
      0: bt = 44'h044_00_01_10_10;
      1: bt = 44'h964_01_01_00_C1;
      2: bt = 44'h0B5_01_00_14_04;
      3: bt = 44'h4B5_01_01_14_04;
      4: bt = 44'h186_00_00_04_FE;
      5: bt = 44'h586_00_01_04_FE;
      6: bt = 44'h237_01_00_0C_08;
      7: bt = 44'h637_01_00_0C_08;
      8: bt = 44'h2E8_00_40_00_81;
      9: bt = 44'h309_41_40_00_81;
      10: bt = 44'h12A_00_00_00_85;
      11: bt = 44'h30A_01_00_00_81;
      12: bt = 44'h2EA_00_40_00_81;
      13: bt = 44'h2E5_01_00_00_81;
      14: bt = 44'h049_01_01_10_00;
      default: bt = 44'h0F8_00_00_14_84;
    endcase
  endfunction

  initial begin
    repeat (4000) @(posedge mclk);
    fails = fails + 1;
    report_and_stop;
  end

  initial begin
    nrst = 1'b0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsAddress = 6'h00;
    avsWritedata = 32'h0;
    fails = 0;
    compares = 0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rc(`BCDU_OFS_ACC, 32'h0);
    rc(`BCDU_OFS_STAT, 32'h0);
    wr(`BCDU_OFS_AUX, 32'h5A);
    for (i = 0; i < 16; i = i + 1) begin
      t = {28'h0, VEC[i * 16 +: 16]};
      e = adj(i[0], t[15:8], t[7:0]);
      op({8'h00, i[0] ? `BCDU_OP_ADJ_SUB : `BCDU_OP_ADJ_ADD}, t[15:8], t[7:0]);
      rc(`BCDU_OFS_ACC, {24'h0, e[15:8]});
      rc(`BCDU_OFS_STATUS_WORD_LOW_HALF, {24'h0, e[7:0]});
    end
    rc(`BCDU_OFS_AUX, 32'h5A);
    for (i = 0; i < 2; i = i + 1) begin
      op({8'h00, `BCDU_OP_SIGN_EXT}, i[0] ? 8'h80 : 8'h7F, 8'hD5);
      rc(`BCDU_OFS_ACC, i[0] ? 32'hFF : 32'h00);
      rc(`BCDU_OFS_AUX, i[0] ? 32'h80 : 32'h7F);
      rc(`BCDU_OFS_STATUS_WORD_LOW_HALF, 32'hD5);
    end
    wr(`BCDU_OFS_SADDR, 32'h10);
    wr(`BCDU_OFS_SFR, 32'h04);
    wr(`BCDU_OFS_AUX, 32'hFE);
    wr(`BCDU_OFS_STATUS_WORD_HIGH_HALF, 32'h08);
    for (i = 0; i < 16; i = i + 1) begin
      t = bt(i);
      op(t[43:32], 8'h81, t[31:24]);
      rc(`BCDU_OFS_STATUS_WORD_LOW_HALF, {24'h0, t[23:16]});
      rc(t[13:8], {24'h0, t[7:0]});
    end
    rc(`BCDU_OFS_STAT, 32'h1);
    wr(`BCDU_OFS_CMD, 32'h0);
    rc(`BCDU_OFS_STAT, 32'h0);
    wr(`BCDU_OFS_STATUS_WORD_HIGH_HALF, 32'h08);
    cp(1'b1);
    rc(`BCDU_OFS_STAT, 32'h1);
    rc(`BCDU_OFS_STAT, 32'h1);
    wr(`BCDU_OFS_CMD, 32'h0);
    cp(1'b0);
    rc(`BCDU_OFS_STAT, 32'h0);
    wr(6'h24, 32'hFF);
    rc(6'h24, 32'h0);
    rc(`BCDU_OFS_CMD, 32'h0);
    report_and_stop;
  end
endmodule // testbench

bind bcdu_core bcdu_checker #(.ADDR_W(ADDR_W)) bcdu_checker_inst (.mclk(mclk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .intAckBlock(intAckBlock));
